//--- logic/sab_consts.svh
`ifndef SERVICE_BUS_CONSTS_SVH
`define SERVICE_BUS_CONSTS_SVH
`define SBUS_ADDR_W 36
`define SBUS_SLV_HI 35
`define SBUS_SLV_LO 32
`define SBUS_LOW_HI 31
`define SBUS_LOW_LO 0
`define SBUS_HALF_BIT 0
`define SBUS_WORD_HI 1
`define SBUS_WORD_LO 0
`define SBUS_SLV_NONE 4'h0
`define SBUS_SLV_DBG 4'h1
`define SBUS_SLV_SYS 4'h4
`define SBUS_SLV_SYSALT 4'h5
`define SBUS_SLV_MTS 4'h6
`define SBUS_SZ_BYTE 2'h0
`define SBUS_SZ_HALF 2'h1
`define SBUS_SZ_WORD 2'h2
`define SBUS_DCC_LO 36'h100000110
`define SBUS_DCC_HI 36'h100000118
`define SBUS_UPAGE_LO 36'h580800000
`define SBUS_UPAGE_HI 36'h581000000
`define SBUS_FCTL_LO 36'h5FFFE0000
`define SBUS_FCTL_HI 36'h5FFFE0400
`define SBUS_FLASH_BASE 36'h580000000
`define SBUS_RATIO_W 16
`define SBUS_RATIO_ONE 16'h0001
`define SBUS_RATIO_MAX 16'hFFFF
`endif

//--- logic/sab_decoder.sv
// What this block does
// [R1] Accesses carry a 36-bit address
// [R2] Byte, halfword and word transfers supported
// [R3] Initiator aligns each access to size
// [R4] Top nibble selects slave, low 32 forwarded
// [R5] 0 unallocated, 1 debug, 4 system bus
// [R6] Slave 5 aliases system bus space
// [R7] Slave 6 test unit, others reserved
// [R8] Master bridges debugger clock to bus clock
// [R9] No debugger rate limit; needs system clock
// [R10] Debugger activity restarts clock, stays asleep
// [R11] Debugger can measure clock ratio
// [R12] System bus reached through bridge
// [R13] Security measures block or allow ranges
// [R14] Security bit forbids programming and debugging
// [R15] Security: debug comm regs, user page read
// [R16] Code restriction: flash controller, unprotected pages
// [R17] Blocked or reserved access ends in error
`timescale 1ns/100ps
`include "sab_consts.svh"
module service_access_bus_decoder
  import service_bus_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESETN,
  // Debugger side, inputs in debugger clock domain, outputs from CLOCK
  input wire logic DBG_CLK,
  input wire logic DBG_REQ_TGL,
  input wire bus_req_s DBG_REQ,
  output logic DBG_ACK_TGL,
  output logic DBG_ERR,
  output logic [31:0] DBG_RDATA,
  output logic [15:0] DBG_RATIO,
  // Power management
  output logic CLK_RESTART_REQ,
  // Security controls
  input wire logic SEC_BIT,
  input wire logic SEC_USER_CODE,
  input wire logic [35:0] BOOT_PROTECT_SIZE,
  input wire logic [35:0] FLASH_SIZE,
  // Slave side
  output logic SLV_VALID,
  output slv_req_s SLV_REQ,
  input wire logic SLV_DONE,
  input wire logic SLV_ERR,
  input wire logic [31:0] SLV_RDATA
);
  typedef struct packed {
    logic [1:0] tgl_sync;
    logic tgl_seen;
    bus_req_s req_meta;
    bus_req_s req_sync;
    logic [1:0] clk_sync;
    logic clk_prev;
    logic [`SBUS_RATIO_W-1:0] cnt;
    logic [`SBUS_RATIO_W-1:0] ratio;
    bus_state_e st;
    logic ack_tgl;
    logic err;
    logic [31:0] rdata;
    logic restart;
    logic valid;
    slv_req_s req;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  logic [35:0] addr;
  logic [3:0] sel;
  logic new_req;
  logic misalign;
  logic slave_ok;
  logic sec_ok;
  logic dcc_hit;
  logic upage_hit;
  logic upage_read;
  logic fctl_hit;
  logic flash_hit;
  logic refuse;
  logic [35:0] fl_lo;
  logic [35:0] fl_hi;

  always_comb begin
    s_nxt = s_r;

    // [R1] Full address from synchronised request
    addr = s_r.req_sync.addr;

    // [R4] Slave number split
    sel = addr[`SBUS_SLV_HI:`SBUS_SLV_LO];

    // [R2] Size and alignment check
    unique case (s_r.req_sync.size)
      `SBUS_SZ_BYTE: begin
        misalign = 1'b0;
      end
      `SBUS_SZ_HALF: begin
        misalign = addr[`SBUS_HALF_BIT];
      end
      `SBUS_SZ_WORD: begin
        misalign = |addr[`SBUS_WORD_HI:`SBUS_WORD_LO];
      end
      default: begin
        misalign = 1'b1;
      end
    endcase

    // [R5] [R6] [R7] Slave map
    unique case (sel)
      `SBUS_SLV_DBG: begin
        slave_ok = 1'b1;
      end
      `SBUS_SLV_SYS: begin
        slave_ok = 1'b1;
      end
      `SBUS_SLV_SYSALT: begin
        slave_ok = 1'b1;
      end
      `SBUS_SLV_MTS: begin
        slave_ok = 1'b1;
      end
      default: begin
        slave_ok = 1'b0;
      end
    endcase

    // [R13] Range windows
    dcc_hit = (addr >= `SBUS_DCC_LO) &&
      (addr <= `SBUS_DCC_HI);
    upage_hit = (addr >= `SBUS_UPAGE_LO) &&
      (addr < `SBUS_UPAGE_HI);
    upage_read = upage_hit && !s_r.req_sync.write;
    fctl_hit = (addr >= `SBUS_FCTL_LO) &&
      (addr < `SBUS_FCTL_HI);
    fl_lo = `SBUS_FLASH_BASE + BOOT_PROTECT_SIZE;
    fl_hi = `SBUS_FLASH_BASE + FLASH_SIZE;
    flash_hit = (addr >= fl_lo) &&
      (addr < fl_hi);

    // [R14] [R15] Security bit restrictions
    if (SEC_BIT) begin
      sec_ok = dcc_hit || upage_read;
    // [R16] User code programming restrictions
    end else if (SEC_USER_CODE) begin
      sec_ok = dcc_hit || upage_read || fctl_hit || flash_hit;
    end else begin
      sec_ok = 1'b1;
    end

    refuse = misalign || !slave_ok || !sec_ok;

    // [R8] Two-flop crossings
    s_nxt.tgl_sync = {s_r.tgl_sync[0], DBG_REQ_TGL};
    s_nxt.req_meta = DBG_REQ;
    s_nxt.req_sync = s_r.req_meta;
    s_nxt.clk_sync = {s_r.clk_sync[0], DBG_CLK};
    s_nxt.clk_prev = s_r.clk_sync[1];

    new_req = s_r.tgl_sync[1] != s_r.tgl_seen;

    // [R11] Cycles per debugger clock period
    if (s_r.clk_sync[1] && !s_r.clk_prev) begin
      s_nxt.ratio = s_r.cnt;
      s_nxt.cnt = `SBUS_RATIO_ONE;
    end else if (s_r.cnt != `SBUS_RATIO_MAX) begin
      s_nxt.cnt = s_r.cnt + `SBUS_RATIO_ONE;
    end

    // [R10] Clock restart on debugger activity
    s_nxt.restart = new_req || (s_r.st != ST_IDLE);

    unique case (s_r.st)
      ST_IDLE: begin
        if (new_req) begin
          s_nxt.tgl_seen = s_r.tgl_sync[1];
          // [R17] Refused access ends in error
          if (refuse) begin
            s_nxt.err = 1'b1;
            s_nxt.rdata = '0;
            s_nxt.st = ST_DONE;
          end else begin
            // [R12] Forward to slave or bridge
            s_nxt.valid = 1'b1;
            s_nxt.req.sel = sel;
            s_nxt.req.addr = addr[`SBUS_LOW_HI:`SBUS_LOW_LO];
            s_nxt.req.size = s_r.req_sync.size;
            s_nxt.req.write = s_r.req_sync.write;
            s_nxt.req.wdata = s_r.req_sync.wdata;
            s_nxt.st = ST_WAIT;
          end
        end
      end

      ST_WAIT: begin
        // [R9] Completes only on running clock
        if (SLV_DONE) begin
          s_nxt.valid = 1'b0;
          s_nxt.err = SLV_ERR;
          s_nxt.rdata = SLV_RDATA;
          s_nxt.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_nxt.ack_tgl = ~s_r.ack_tgl;
        s_nxt.st = ST_IDLE;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign DBG_ACK_TGL = s_r.ack_tgl;
  assign DBG_ERR = s_r.err;
  assign DBG_RDATA = s_r.rdata;
  assign DBG_RATIO = s_r.ratio;
  assign CLK_RESTART_REQ = s_r.restart;
  assign SLV_VALID = s_r.valid;
  assign SLV_REQ = s_r.req;
endmodule

//--- logic/sab_pkg.sv
package service_bus_pkg;
  typedef struct packed {
    logic [35:0] addr;
    logic [1:0] size;
    logic write;
    logic [31:0] wdata;
  } bus_req_s;
  typedef struct packed {
    logic [3:0] sel;
    logic [31:0] addr;
    logic [1:0] size;
    logic write;
    logic [31:0] wdata;
  } slv_req_s;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} bus_state_e;
endpackage

//--- sim/sab_dbg_model.sv
`timescale 1ns/100ps
module debugger_link_model
  import service_bus_pkg::*;
(
  // Link
  input wire logic clock,
  input wire logic ack_tgl,
  output logic dbg_clk,
  output logic req_tgl,
  output bus_req_s req
);
  initial begin
    dbg_clk = 0;
    req_tgl = 0;
    req = '0;
    #5 forever #24 dbg_clk = ~dbg_clk;
  end
  task automatic access(input bus_req_s r);
    logic a0;
    a0 = ack_tgl;
    req = r;
    req_tgl = ~req_tgl;
    repeat (60) if (ack_tgl === a0) @(posedge clock) #1;
    req = ~r;
    // Let an edge pass so the next request never lands in this time step
    @(posedge clock) #1;
  endtask
endmodule

//--- sim/sab_decoder_bench.sv
`timescale 1ns/100ps
module service_access_bus_decoder_bench;
  import service_bus_pkg::*;
  logic clock = 0, resetn = 0, sec_bit = 0, user_code = 0, slv_done = 0;
  logic dbg_clk, req_tgl, ack_tgl, err, restart, slv_valid;
  logic [35:0] bp = 36'h000010000;
  logic [31:0] rdata;
  logic [15:0] ratio;
  bus_req_s dbg_req;
  slv_req_s slv_req;
  slv_req_s last_req;
  logic restart_seen = 0;
  int mismatches = 0, total_checks = 0;
  debugger_link_model i_debugger_link_model (.clock(clock), .ack_tgl(ack_tgl), .dbg_clk(dbg_clk),
    .req_tgl(req_tgl), .req(dbg_req));
  service_access_bus_decoder i_service_access_bus_decoder (.CLOCK(clock), .RESETN(resetn), .DBG_CLK(dbg_clk),
    .DBG_REQ_TGL(req_tgl),
    .DBG_REQ(dbg_req), .DBG_ACK_TGL(ack_tgl), .DBG_ERR(err), .DBG_RDATA(rdata), .DBG_RATIO(ratio),
    .CLK_RESTART_REQ(restart), .SEC_BIT(sec_bit), .SEC_USER_CODE(user_code), .BOOT_PROTECT_SIZE(bp),
    .FLASH_SIZE(36'h000020000), .SLV_VALID(slv_valid), .SLV_REQ(slv_req), .SLV_DONE(slv_done),
    .SLV_ERR(1'b0), .SLV_RDATA(~slv_req.addr));
  initial forever #2 clock = ~clock;
  always @(posedge clock) slv_done <= #1 slv_valid && !slv_done;
  always @(posedge clock) if (slv_valid && slv_done) last_req <= slv_req;
  always @(posedge clock) if (restart === 1'b1) restart_seen <= 1'b1;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic [35:0] a, input logic [1:0] s, input logic w, input logic e);
    i_debugger_link_model.access({a, s, w, 32'h0000A5A5});
    chk("err", {31'h0, e}, {31'h0, err});
    if (!w) chk("rdata", e ? 32'h0 : ~a[31:0], rdata);
    if (!e) chk("slv_addr", a[31:0], last_req.addr);
    if (!e) chk("slv_sel", {28'h0, a[35:32]}, {28'h0, last_req.sel});
    if (!e) chk("slv_ctl", {29'h0, w, s}, {29'h0, last_req.write, last_req.size});
    if (!e && w) chk("slv_wdata", 32'h0000A5A5, last_req.wdata);
  endtask
  task automatic t_map();
    for (int n = 0; n < 16; n++) acc({n[3:0], 32'h00000010}, 2'h2, 0, !(n inside {1, 4, 5, 6}));
  endtask
  task automatic t_size();
    acc(36'h100000001, 2'h1, 0, 1);
    acc(36'h100000002, 2'h2, 0, 1);
    acc(36'h100000003, 2'h0, 0, 0);
    acc(36'h100000002, 2'h1, 1, 0);
    acc(36'h100000000, 2'h3, 0, 1);
  endtask
  task automatic t_sec();
    sec_bit = 1;
    acc(36'h100000110, 2'h2, 1, 0);
    acc(36'h10000011C, 2'h2, 0, 1);
    acc(36'h580800000, 2'h2, 0, 0);
    acc(36'h580800000, 2'h2, 1, 1);
    acc(36'h581000000, 2'h2, 0, 1);
    sec_bit = 0;
    user_code = 1;
    acc(36'h5FFFE03FC, 2'h2, 1, 0);
    acc(36'h5FFFE0400, 2'h2, 1, 1);
    acc(36'h580000000 + bp, 2'h2, 1, 0);
    acc(36'h580000000 + bp - 36'h4, 2'h2, 0, 1);
    user_code = 0;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    #1 resetn = 1;
    t_map();
    t_size();
    t_sec();
    repeat (2) @(posedge clock);
    #1;
    chk("ratio", 32'h0000000C, {16'h0, ratio});
    chk("restart_seen", 32'h00000001, {31'h0, restart_seen});
    chk("restart_idle", 32'h00000000, {31'h0, restart});
    report_and_stop();
  end
  initial begin
    #20000 mismatches++;
    report_and_stop();
  end
endmodule

//--- sim/sab_decoder_properties.sv
`timescale 1ns/100ps
module service_access_bus_decoder_properties
  import service_bus_pkg::*;
(
  // Watched ports
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic SEC_BIT,
  input wire logic DBG_REQ_TGL,
  input wire bus_req_s DBG_REQ,
  input wire logic DBG_ACK_TGL,
  input wire logic CLK_RESTART_REQ,
  input wire logic SLV_VALID,
  input wire slv_req_s SLV_REQ,
  input wire logic SLV_DONE
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sel_legal_a: assert property (SLV_VALID |-> SLV_REQ.sel inside {4'h1, 4'h4, 4'h5, 4'h6})
    else $error("illegal slave selected");
  sel_fwd_a: assert property ($rose(SLV_VALID) |-> SLV_REQ.sel == DBG_REQ.addr[35:32])
    else $error("slave number not forwarded");
  addr_fwd_a: assert property ($rose(SLV_VALID) |-> SLV_REQ.addr == DBG_REQ.addr[31:0])
    else $error("low address not forwarded");
  size_ok_a: assert property ($rose(SLV_VALID) |-> SLV_REQ.size != 2'h3)
    else $error("illegal size forwarded");
  align_ok_a: assert property (SLV_VALID |-> !(SLV_REQ.size == 2'h1 && SLV_REQ.addr[0]) &&
    !(SLV_REQ.size == 2'h2 && (|SLV_REQ.addr[1:0])))
    else $error("misaligned access forwarded");
  done_ack_a: assert property (SLV_VALID && SLV_DONE |=> !SLV_VALID ##1 $changed(DBG_ACK_TGL))
    else $error("ack not two cycles after done");
  clk_wake_a: assert property ($changed(DBG_REQ_TGL) |-> ##[1:4] CLK_RESTART_REQ)
    else $error("no clock restart request");
  sec_block_a: assert property ($rose(SLV_VALID) && SEC_BIT |->
    SLV_REQ.sel == 4'h1 || (SLV_REQ.sel == 4'h5 && !SLV_REQ.write))
    else $error("secured access forwarded");
  cover property ($rose(SLV_VALID));
  cover property ($rose(SLV_VALID) && SEC_BIT);
  cover property ($changed(DBG_REQ_TGL));
endmodule
bind service_access_bus_decoder service_access_bus_decoder_properties i_service_access_bus_decoder_properties (.*);
